// [flash_host_regs.vh]
`ifndef FLASH_HOST_REGS_VH
`define FLASH_HOST_REGS_VH

// Clock and timing
`define CLK_NS 100
`define ACC_NS 120
`define ACC_CYC ((`ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define OEHP_NS 150
`define OEHP_CYC ((`OEHP_NS + `CLK_NS - 1) / `CLK_NS)
`define BLC_US 150
`define BLC_CYC ((`BLC_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define TWC_MS 10
`define TWC_CYC ((`TWC_MS * 1000000) / `CLK_NS)

// Register byte offsets
`define OFF_CMD 8'h00
`define OFF_ADDR 8'h04
`define OFF_DATA 8'h08
`define OFF_BUF 8'h0C
`define OFF_STATUS 8'h10
`define OFF_RDATA 8'h14
`define OFF_IRQ_STAT 8'h18
`define OFF_IRQ_CLR 8'h1C
`define OFF_IRQ_EN 8'h20

// Operation codes in the command register
`define OP_CMD_LOAD 3'h1
`define OP_READ 3'h2
`define OP_PROGRAM 3'h3

// Sizes and field positions
`define SECTOR_BYTES 256
`define CMD_ADDR_MSB 14
`define TOGGLE_BIT 6
`define POLL_BIT 7
`define IRQ_DONE 0
`define IRQ_TIMEOUT 1
`define IRQ_BITS 2

`endif

// [flash_strobe_engine.v]
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_regs.vh"

module flash_strobe_engine (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Request
  input wire start,
  input wire wr,
  input wire [18:0] addr_in,
  input wire [7:0] wdata,
  output reg [7:0] rdata,
  output reg done,
  // Flash pins
  input wire [7:0] dq_in,
  output reg ce_n,
  output reg oe_n,
  output reg we_n,
  output reg [18:0] addr,
  output reg [7:0] dq_out,
  output reg dq_oe
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_W_SETUP = 3'd1;
  localparam [2:0] S_W_LOW = 3'd2;
  localparam [2:0] S_W_HOLD = 3'd3;
  localparam [2:0] S_R_WAIT = 3'd4;
  localparam [2:0] S_R_SAMP = 3'd5;
  localparam [2:0] S_R_REC = 3'd6;
  localparam [31:0] ACC_LIM = `ACC_CYC;
  localparam [31:0] OEHP_LIM = `OEHP_CYC;

  reg [2:0] state_reg;
  reg [3:0] cnt_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      rdata <= 8'h00;
      done <= 1'b0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      addr <= 19'h00000;
      dq_out <= 8'h00;
      dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            addr <= addr_in;
            dq_out <= wdata;
            ce_n <= 1'b0;
            if (wr) begin
              // Output gate stays high through the whole byte load
              dq_oe <= 1'b1;
              state_reg <= S_W_SETUP;
            end else begin
              oe_n <= 1'b0;
              cnt_reg <= ACC_LIM[3:0];
              state_reg <= S_R_WAIT;
            end
          end
        end
        S_W_SETUP: begin
          we_n <= 1'b0;
          state_reg <= S_W_LOW;
        end
        S_W_LOW: begin
          // Data is taken by the device on this rising edge
          we_n <= 1'b1;
          state_reg <= S_W_HOLD;
        end
        S_W_HOLD: begin
          ce_n <= 1'b1;
          dq_oe <= 1'b0;
          done <= 1'b1;
          state_reg <= S_IDLE;
        end
        S_R_WAIT: begin
          if (cnt_reg == 4'h1) begin
            state_reg <= S_R_SAMP;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        S_R_SAMP: begin
          rdata <= dq_in;
          oe_n <= 1'b1;
          ce_n <= 1'b1;
          cnt_reg <= OEHP_LIM[3:0];
          state_reg <= S_R_REC;
        end
        S_R_REC: begin
          // Keeps the gate high long enough for the toggle line to flip
          if (cnt_reg == 4'h1) begin
            done <= 1'b1;
            state_reg <= S_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [flash_host.v]
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_regs.vh"

module flash_host #(
  parameter [23:0] TWC_CYCLES = `TWC_CYC
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Interrupt
  output reg irq,
  // Flash pins
  input wire [7:0] dq_in,
  output wire ce_n,
  output wire oe_n,
  output wire we_n,
  output wire [18:0] addr,
  output wire [7:0] dq_out,
  output wire dq_oe
);

  localparam [2:0] M_IDLE = 3'd0;
  localparam [2:0] M_SINGLE = 3'd1;
  localparam [2:0] M_LOAD = 3'd2;
  localparam [2:0] M_LAPSE = 3'd3;
  localparam [2:0] M_POLL = 3'd4;
  localparam [31:0] BLC_LIM = `BLC_CYC;

  function mapped;
    input [7:0] a;
    begin
      mapped = (a <= `OFF_IRQ_EN) && (a[1:0] == 2'b00);
    end
  endfunction

  reg [2:0] state_reg;
  reg [18:0] addr_reg;
  reg [7:0] data_reg;
  reg [7:0] rd_reg;
  reg [7:0] buf_mem [0:`SECTOR_BYTES-1];
  reg [7:0] idx_reg;
  reg issued_reg;
  reg start_reg;
  reg wr_reg;
  reg [18:0] eaddr_reg;
  reg [7:0] ewdata_reg;
  reg [23:0] wait_reg;
  reg [23:0] twc_reg;
  reg have_prev_reg;
  reg prev_tog_reg;
  reg [`IRQ_BITS-1:0] irq_stat_reg;
  reg [`IRQ_BITS-1:0] irq_en_reg;
  reg [`IRQ_BITS-1:0] irq_set;
  wire [`IRQ_BITS-1:0] irq_clr;
  wire [7:0] e_rdata;
  wire e_done;
  wire wr_fire;
  wire [31:0] wd;

  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign wd = s_axi_wdata;
  assign irq_clr = (wr_fire && s_axi_awaddr == `OFF_IRQ_CLR) ? wd[`IRQ_BITS-1:0] : 2'h0;

  flash_strobe_engine engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_reg),
    .wr(wr_reg),
    .addr_in(eaddr_reg),
    .wdata(ewdata_reg),
    .rdata(e_rdata),
    .done(e_done),
    .dq_in(dq_in),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n),
    .addr(addr),
    .dq_out(dq_out),
    .dq_oe(dq_oe)
  );

  // Write channel: address and data taken together, one at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      addr_reg <= 19'h00000;
      data_reg <= 8'h00;
      irq_en_reg <= 2'h0;
    end else begin
      s_axi_awready <= wr_fire;
      s_axi_wready <= wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(s_axi_awaddr) ? 2'b00 : 2'b10;
        if (s_axi_awaddr == `OFF_ADDR) begin
          addr_reg <= wd[18:0];
        end
        if (s_axi_awaddr == `OFF_DATA) begin
          data_reg <= wd[7:0];
        end
        if (s_axi_awaddr == `OFF_IRQ_EN) begin
          irq_en_reg <= wd[`IRQ_BITS-1:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Sector buffer: index in bits 15:8, byte in bits 7:0
  always @(posedge aclk) begin
    if (wr_fire && s_axi_awaddr == `OFF_BUF) begin
      buf_mem[wd[15:8]] <= wd[7:0];
    end
  end

  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
        case (s_axi_araddr)
          `OFF_ADDR: s_axi_rdata <= {13'h0000, addr_reg};
          `OFF_DATA: s_axi_rdata <= {24'h000000, data_reg};
          `OFF_STATUS: s_axi_rdata <= {29'h00000000, state_reg};
          `OFF_RDATA: s_axi_rdata <= {24'h000000, rd_reg};
          `OFF_IRQ_STAT: s_axi_rdata <= {30'h00000000, irq_stat_reg};
          `OFF_IRQ_EN: s_axi_rdata <= {30'h00000000, irq_en_reg};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Sticky interrupt bits; a set in the clearing cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_BITS; gi = gi + 1) begin : g_irq
      always @(posedge aclk) begin
        if (!aresetn) begin
          irq_stat_reg[gi] <= 1'b0;
        end else begin
          irq_stat_reg[gi] <= irq_set[gi] | (irq_stat_reg[gi] & ~irq_clr[gi]);
        end
      end
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // Sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= M_IDLE;
      rd_reg <= 8'h00;
      idx_reg <= 8'h00;
      issued_reg <= 1'b0;
      start_reg <= 1'b0;
      wr_reg <= 1'b0;
      eaddr_reg <= 19'h00000;
      ewdata_reg <= 8'h00;
      wait_reg <= 24'h000000;
      twc_reg <= 24'h000000;
      have_prev_reg <= 1'b0;
      prev_tog_reg <= 1'b0;
      irq_set <= 2'h0;
    end else begin
      start_reg <= 1'b0;
      irq_set <= 2'h0;
      case (state_reg)
        M_IDLE: begin
          issued_reg <= 1'b0;
          // Commands arriving while busy are dropped
          if (wr_fire && s_axi_awaddr == `OFF_CMD) begin
            if (wd[2:0] == `OP_CMD_LOAD) begin
              wr_reg <= 1'b1;
              eaddr_reg <= {4'h0, addr_reg[`CMD_ADDR_MSB:0]};
              ewdata_reg <= data_reg;
              start_reg <= 1'b1;
              state_reg <= M_SINGLE;
            end else if (wd[2:0] == `OP_READ) begin
              wr_reg <= 1'b0;
              eaddr_reg <= addr_reg;
              start_reg <= 1'b1;
              state_reg <= M_SINGLE;
            end else if (wd[2:0] == `OP_PROGRAM) begin
              idx_reg <= 8'h00;
              state_reg <= M_LOAD;
            end
          end
        end
        M_SINGLE: begin
          if (e_done) begin
            rd_reg <= e_rdata;
            irq_set[`IRQ_DONE] <= 1'b1;
            state_reg <= M_IDLE;
          end
        end
        M_LOAD: begin
          // Loads run back to back, a handful of cycles apart
          if (!issued_reg) begin
            wr_reg <= 1'b1;
            eaddr_reg <= {addr_reg[18:8], idx_reg};
            ewdata_reg <= buf_mem[idx_reg];
            start_reg <= 1'b1;
            issued_reg <= 1'b1;
          end else if (e_done) begin
            issued_reg <= 1'b0;
            idx_reg <= idx_reg + 8'h01;
            if (idx_reg == 8'hFF) begin
              wait_reg <= BLC_LIM[23:0];
              twc_reg <= 24'h000000;
              have_prev_reg <= 1'b0;
              state_reg <= M_LAPSE;
            end
          end
        end
        M_LAPSE: begin
          twc_reg <= twc_reg + 24'h000001;
          if (wait_reg == 24'h000001) begin
            state_reg <= M_POLL;
          end else begin
            wait_reg <= wait_reg - 24'h000001;
          end
        end
        M_POLL: begin
          twc_reg <= twc_reg + 24'h000001;
          if (!issued_reg) begin
            wr_reg <= 1'b0;
            // Last loaded byte, so the poll line compares against its true data
            eaddr_reg <= {addr_reg[18:8], 8'hFF};
            start_reg <= 1'b1;
            issued_reg <= 1'b1;
          end else if (e_done) begin
            issued_reg <= 1'b0;
            rd_reg <= e_rdata;
            have_prev_reg <= 1'b1;
            prev_tog_reg <= e_rdata[`TOGGLE_BIT];
            if (have_prev_reg && e_rdata[`TOGGLE_BIT] == prev_tog_reg &&
                e_rdata[`POLL_BIT] == buf_mem[8'hFF][`POLL_BIT]) begin
              irq_set[`IRQ_DONE] <= 1'b1;
              state_reg <= M_IDLE;
            end else if (twc_reg >= TWC_CYCLES) begin
              irq_set[`IRQ_TIMEOUT] <= 1'b1;
              state_reg <= M_IDLE;
            end
          end
        end
        default: begin
          state_reg <= M_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [flash_host_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_host_monitor (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // Flash pins
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire [18:0] addr,
  input wire dq_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence load_pulse;
    $fell(we_n) ##1 $rose(we_n) ##1 $rose(ce_n);
  endsequence
  sequence read_strobe;
    (!oe_n)[*3] ##1 (oe_n && ce_n);
  endsequence
  a_strobe_excl: assert property (oe_n || we_n)
    else $error("read and write strobes low together");
  a_load_shape: assert property ($fell(ce_n) && dq_oe |=> load_pulse)
    else $error("byte load pulse malformed");
  a_bus_release: assert property (!oe_n |-> !dq_oe)
    else $error("data bus driven during read");
  a_read_shape: assert property ($fell(oe_n) |-> read_strobe)
    else $error("read strobe malformed");
  a_read_gap: assert property ($rose(oe_n) |=> oe_n)
    else $error("read strobe high pulse too short");
  a_addr_hold: assert property (!ce_n && !$fell(ce_n) |-> $stable(addr))
    else $error("address moved during access");
  a_write_ack: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
    |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
    else $error("write not accepted in one cycle");
  a_read_ack: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_arready && s_axi_rvalid)
    else $error("read not answered in one cycle");
endmodule
bind flash_host flash_host_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .ce_n(ce_n), .oe_n(oe_n),
  .we_n(we_n), .addr(addr), .dq_oe(dq_oe));
`default_nettype wire

// [flash_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
  // Strobes
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  // Address and data
  input wire logic [18:0] addr,
  input wire logic [7:0] dq_out,
  output logic [7:0] dq_in
);
  logic [7:0] mem [int];
  logic [7:0] lat [int];
  logic [18:0] last_addr = 19'h00000;
  logic [10:0] sec = 11'h000;
  logic [7:0] last = 8'h00;
  logic [7:0] rd = 8'h00;
  logic busy = 1'b0;
  logic tog = 1'b0;
  int prog_ns = 50000;
  int loads = 0;
  int got_loads = 0;
  int sec_err = 0;
  realtime t_last = 0;
  // Loads are ignored while the self-timed cycle runs
  always @(posedge we_n) begin
    if (!ce_n && !busy) begin
      if (loads > 0 && addr[18:8] !== sec) sec_err++;
      sec = addr[18:8];
      lat[addr[7:0]] = dq_out;
      last = dq_out;
      last_addr = addr;
      loads++;
      t_last = $realtime;
    end
  end
  always #100 begin
    if (loads > 0 && $realtime - t_last >= 150000.0) begin
      busy = 1'b1;
      got_loads = loads;
      loads = 0;
      #(prog_ns);
      for (int i = 0; i < 256; i++) begin
        mem[{sec, i[7:0]}] = lat.exists(i) ? lat[i] : 8'hXX;
      end
      lat.delete();
      busy = 1'b0;
    end
  end
  // Strobes fall together; the delay lets both settle first
  always @(negedge oe_n) begin
    #1;
    if (!ce_n && busy) begin
      tog = ~tog;
      rd = {~last[7], tog, 6'h00};
    end else if (!ce_n) begin
      rd = mem.exists(addr) ? mem[addr] : 8'hFF;
    end
  end
  // A released bus shows the inverse so a stale sample never matches by luck
  assign dq_in = (!ce_n && !oe_n) ? rd : ~rd;
endmodule
`default_nettype wire

// [flash_host_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_regs.vh"
module flash_host_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic ce_n, oe_n, we_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [18:0] addr;
  logic [7:0] dq_in, dq_out;
  int err_total = 0;
  int checks = 0;
  always #50 aclk = ~aclk;
  flash_host #(.TWC_CYCLES(24'd3000)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq), .dq_in(dq_in),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_out(dq_out), .dq_oe());
  flash_dev_model u_mem (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
    .dq_out(dq_out), .dq_in(dq_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, r);
    // One idle edge so the next call never re-raises a valid in this step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk(s_axi_rresp, r);
    @(posedge aclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d, 2'b00);
    chk(d, e);
  endtask
  task automatic wait_idle();
    logic [31:0] d;
    d = 32'h1;
    for (int i = 0; i < 4000 && d !== 32'h0; i++) rd(`OFF_STATUS, d, 2'b00);
  endtask
  function automatic logic [7:0] pat(input logic [10:0] s, input logic [7:0] i);
    return i * 8'h07 + s[7:0];
  endfunction
  task automatic read_byte(input logic [18:0] a, input logic [7:0] e);
    wr(`OFF_ADDR, {13'h0, a}, 2'b00);
    wr(`OFF_CMD, 32'h2, 2'b00);
    wait_idle();
    rc(`OFF_RDATA, {24'h0, e});
  endtask
  task automatic t_regs();
    logic [31:0] d;
    rc(`OFF_STATUS, 32'h0);
    rc(`OFF_IRQ_STAT, 32'h0);
    rc(`OFF_IRQ_EN, 32'h0);
    rd(8'h40, d, 2'b10);
    chk(d, 32'h0);
    wr(8'h40, 32'h1, 2'b10);
    wr(`OFF_ADDR, 32'hFFFFFFFF, 2'b00);
    rc(`OFF_ADDR, 32'h7FFFF);
    rc(`OFF_IRQ_CLR, 32'h0);
    $display("test registers done");
  endtask
  task automatic t_irq();
    u_mem.mem[19'h12345] = 8'h5A;
    read_byte(19'h12345, 8'h5A);
    rc(`OFF_IRQ_STAT, 32'h1);
    chk(irq, 1'b0);
    wr(`OFF_IRQ_EN, 32'h3, 2'b00);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    wr(`OFF_IRQ_CLR, 32'h1, 2'b00);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    $display("test interrupt done");
  endtask
  task automatic t_cmd();
    wr(`OFF_ADDR, 32'h7AAAA, 2'b00);
    wr(`OFF_DATA, 32'h55, 2'b00);
    wr(`OFF_CMD, 32'h1, 2'b00);
    wait_idle();
    chk(u_mem.last_addr, 19'h02AAA);
    chk(u_mem.last, 8'h55);
    wait (u_mem.busy);
    wait (!u_mem.busy);
    wr(`OFF_IRQ_CLR, 32'h3, 2'b00);
    $display("test command load done");
  endtask
  task automatic t_prog(input logic [10:0] s, input logic slow);
    u_mem.prog_ns = slow ? 400000 : 50000;
    for (int i = 0; i < 256; i++) wr(`OFF_BUF, {16'h0, i[7:0], pat(s, i[7:0])}, 2'b00);
    wr(`OFF_ADDR, {13'h0, s, 8'h00}, 2'b00);
    wr(`OFF_CMD, 32'h3, 2'b00);
    wait_idle();
    rc(`OFF_IRQ_STAT, slow ? 32'h2 : 32'h1);
    chk(irq, 1'b1);
    chk(u_mem.got_loads, 256);
    chk(u_mem.sec_err, 0);
    wait (!u_mem.busy);
    wr(`OFF_IRQ_CLR, 32'h3, 2'b00);
    read_byte({s, 8'h00}, pat(s, 8'h00));
    read_byte({s, 8'hFF}, pat(s, 8'hFF));
    wr(`OFF_IRQ_CLR, 32'h3, 2'b00);
    $display("test program %h done", s);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_irq();
    t_cmd();
    t_prog(11'h123, 1'b0);
    t_prog(11'h0F0, 1'b1);
    summarize();
  end
  initial begin
    #(80000 * 100);
    err_total++;
    summarize();
  end
endmodule
`default_nettype wire
